//--- core/pbc_control.sv
// Behaviour
// - Speed field is bit 6 high, bit 13 low; 10=1G, 01=100M, 00=10M, 11 reserved.
// - Speed has no fixed default; it loads from straps, and reads 10M while hard reset is held.
// - Bit 12 enables negotiation; default taken from the strap.
// - Speed, negotiation enable and power-down defaults load from strap pins.
// - Bit 11 sets software power-down; clearing resumes normal operation.
// - Power-down strapped high keeps the device idle until software clears it.
// - Bit 10 isolates: mac_out_enable drops to tristate the MAC outputs, transmit_enable is not gated by it; default off.
// - Writing 1 to bit 9 restarts negotiation; self clears once taken.
// - Bit 7 enables the collision signal test; default off.
// - Bit 5 reads zero; transmit only after a valid link.
// - Writing 1 to bit 15 soft resets; bit self clears when done.
// - Bit 14 enables loopback; default off.
`timescale 1ns/1ps
`include "pbc_params.svh"
module pbc_control
  import pbc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire pbc_strap_t  strap,
  input  wire logic        wr_en,
  input  wire logic [4:0]  reg_addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        neg_restart_ack,
  input  wire logic        link_valid,
  output logic      [15:0] rd_data,
  output pbc_ctrl_t        ctrl,
  output logic             negotiation_restart,
  output logic             soft_reset,
  output logic             mac_out_enable,
  output logic             transmit_enable,
  output logic             speed_reserved
);
  // Control group
  pbc_state_t            st_q;
  pbc_state_t            st_d;
  logic [`PBC_CNT_W-1:0] cnt_q;
  logic [`PBC_CNT_W-1:0] cnt_d;
  pbc_ctrl_t             c_q;
  pbc_ctrl_t             c_d;
  logic                  rstrt_q;
  logic                  rstrt_d;
  logic                  srst_q;
  logic                  srst_d;
  // Output group
  logic [15:0]           rd_q;
  logic [15:0]           rd_d;
  logic                  oe_q;
  logic                  oe_d;
  logic                  tx_q;
  logic                  tx_d;
  logic                  rsv_q;
  logic                  rsv_d;

  function automatic pbc_ctrl_t strap_defaults(input pbc_strap_t s);
    pbc_ctrl_t r;
    r = '0;
    r.speed              = s.speed;
    r.negotiation_enable = s.neg_enable;
    r.soft_power_down    = s.power_down;
    return r;
  endfunction

  function automatic logic [15:0] pack_reg(input pbc_ctrl_t c,
                                           input logic      sr,
                                           input logic      rs);
    logic [15:0] v;
    v = 16'h0000;
    v[`PBC_BIT_SOFT_RST] = sr;
    v[`PBC_BIT_LOOPBACK] = c.loopback;
    v[`PBC_BIT_SPEED_LO] = c.speed[0];
    v[`PBC_BIT_NEG_EN]   = c.negotiation_enable;
    v[`PBC_BIT_PWR_DOWN] = c.soft_power_down;
    v[`PBC_BIT_ISOLATE]  = c.isolate;
    v[`PBC_BIT_NEG_RST]  = rs;
    v[`PBC_BIT_DUPLEX]   = c.full_duplex_select;
    v[`PBC_BIT_COLLISION_SIGNAL_TEST]  = c.collision_signal_test;
    v[`PBC_BIT_SPEED_HI] = c.speed[1];
    return v;
  endfunction

  function automatic pbc_ctrl_t apply_write(input pbc_ctrl_t   c,
                                            input logic [15:0] d);
    pbc_ctrl_t r;
    r                       = c;
    r.loopback              = d[`PBC_BIT_LOOPBACK];
    r.speed                 = {d[`PBC_BIT_SPEED_HI], d[`PBC_BIT_SPEED_LO]};
    r.negotiation_enable    = d[`PBC_BIT_NEG_EN];
    r.soft_power_down       = d[`PBC_BIT_PWR_DOWN];
    r.isolate               = d[`PBC_BIT_ISOLATE];
    r.full_duplex_select    = d[`PBC_BIT_DUPLEX];
    r.collision_signal_test = d[`PBC_BIT_COLLISION_SIGNAL_TEST];
    return r;
  endfunction

  function automatic logic is_reserved(input logic [1:0] s);
    return s == `PBC_SPEED_RSVD;
  endfunction

  // Isolation tristates the MAC side regardless of link state
  function automatic logic drives_mac(input pbc_ctrl_t c,
                                      input logic      sr);
    return !c.isolate && !c.soft_power_down && !sr;
  endfunction

  // A strapped power-down keeps transmit off until software clears it
  function automatic logic may_transmit(input pbc_ctrl_t c,
                                        input logic      sr,
                                        input logic      link);
    return link && !c.soft_power_down && !sr;
  endfunction

  function automatic logic addr_hit(input logic [4:0] a);
    return a == `PBC_REG_ADDR;
  endfunction

  function automatic logic count_done(input logic [`PBC_CNT_W-1:0] n);
    return n == `PBC_CNT_W'(`PBC_RST_CYCLES - 1);
  endfunction

  logic wr_hit;
  logic ack_hit;
  assign wr_hit  = wr_en && addr_hit(reg_addr);
  assign ack_hit = rstrt_q && neg_restart_ack;

  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    c_d     = c_q;
    rstrt_d = rstrt_q;
    srst_d  = srst_q;
    // Ack honoured in every state so a restart never sticks
    if (ack_hit) begin
      rstrt_d = 1'b0;
    end
    case (st_q)
      PBC_LOAD: begin
        // Straps sampled after release, never under the async reset
        c_d     = strap_defaults(strap);
        rstrt_d = 1'b0;
        srst_d  = 1'b0;
        st_d    = PBC_IDLE;
      end
      PBC_RESET: begin
        // Soft reset holds writes off until the count ends
        if (count_done(cnt_q)) begin
          st_d = PBC_LOAD;
        end else begin
          cnt_d = cnt_q + `PBC_CNT_W'(1);
        end
      end
      PBC_IDLE: begin
        if (wr_hit && wr_data[`PBC_BIT_SOFT_RST]) begin
          // Rest of the word is dropped; the reload overwrites it anyway
          srst_d = 1'b1;
          cnt_d  = '0;
          st_d   = PBC_RESET;
        end else if (wr_hit) begin
          c_d = apply_write(c_q, wr_data);
          if (wr_data[`PBC_BIT_NEG_RST]) begin
            // Set wins over a same-cycle ack
            rstrt_d = 1'b1;
          end
        end else begin
          // Other addresses belong to other registers
          c_d = c_q;
        end
      end
      default: begin
        st_d = PBC_LOAD;
      end
    endcase
  end

  always_comb begin
    rd_d  = pack_reg(c_d, srst_d, rstrt_d);
    oe_d  = drives_mac(c_d, srst_d);
    tx_d  = may_transmit(c_d, srst_d, link_valid);
    rsv_d = is_reserved(c_d.speed);
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st_q    <= PBC_LOAD;
      cnt_q   <= '0;
      c_q     <= '0;
      rstrt_q <= 1'b0;
      srst_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      c_q     <= c_d;
      rstrt_q <= rstrt_d;
      srst_q  <= srst_d;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_q  <= 16'h0000;
      oe_q  <= 1'b0;
      tx_q  <= 1'b0;
      rsv_q <= 1'b0;
    end else begin
      rd_q  <= rd_d;
      oe_q  <= oe_d;
      tx_q  <= tx_d;
      rsv_q <= rsv_d;
    end
  end

  assign rd_data             = rd_q;
  assign ctrl                = c_q;
  assign negotiation_restart = rstrt_q;
  assign soft_reset          = srst_q;
  assign mac_out_enable      = oe_q;
  assign transmit_enable     = tx_q;
  assign speed_reserved      = rsv_q;
endmodule

//--- core/pbc_params.svh
`ifndef PBC_PARAMS_SVH
`define PBC_PARAMS_SVH
`define PBC_REG_ADDR      5'h00
`define PBC_BIT_SOFT_RST  15
`define PBC_BIT_LOOPBACK  14
`define PBC_BIT_SPEED_LO  13
`define PBC_BIT_NEG_EN    12
`define PBC_BIT_PWR_DOWN  11
`define PBC_BIT_ISOLATE   10
`define PBC_BIT_NEG_RST   9
`define PBC_BIT_DUPLEX    8
`define PBC_BIT_COLLISION_SIGNAL_TEST   7
`define PBC_BIT_SPEED_HI  6
`define PBC_WRITE_MASK    16'hffc0
`define PBC_SPEED_1G      2'h2
`define PBC_SPEED_100M    2'h1
`define PBC_SPEED_10M     2'h0
`define PBC_SPEED_RSVD    2'h3
`define PBC_RST_HOLD_NS   100
`define PBC_CLK_NS        5
`define PBC_RST_CYCLES    ((`PBC_RST_HOLD_NS + `PBC_CLK_NS - 1) / `PBC_CLK_NS)
`define PBC_CNT_W         8
`endif

//--- core/pbc_pkg.sv
package pbc_pkg;
  typedef struct packed {
    logic [1:0] speed;
    logic       neg_enable;
    logic       power_down;
  } pbc_strap_t;
  typedef struct packed {
    logic [1:0] speed;
    logic       negotiation_enable;
    logic       soft_power_down;
    logic       isolate;
    logic       full_duplex_select;
    logic       collision_signal_test;
    logic       loopback;
  } pbc_ctrl_t;
  typedef enum logic [1:0] {
    PBC_IDLE  = 2'b00,
    PBC_RESET = 2'b01,
    PBC_LOAD  = 2'b10
  } pbc_state_t;
endpackage

//--- tb/pbc_control_bench.sv
`timescale 1ns/1ps
module pbc_control_bench;
  import pbc_pkg::*;
  logic        clock = 0, rst = 1, wr_en = 0, ack = 0, link = 1;
  pbc_strap_t  strap = 4'ha;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wdata = 16'h0000, rd;
  pbc_ctrl_t   ctrl;
  logic        restart, srst, mac_en, tx_en, rsvd;
  int          fail_count = 0, n_compared = 0, cyc = 0;
  pbc_control pbc_control_i (.clock(clock), .rst(rst), .strap(strap), .wr_en(wr_en),
    .reg_addr(addr), .wr_data(wdata), .neg_restart_ack(ack), .link_valid(link),
    .rd_data(rd), .ctrl(ctrl), .negotiation_restart(restart), .soft_reset(srst),
    .mac_out_enable(mac_en), .transmit_enable(tx_en), .speed_reserved(rsvd));
  initial forever #2.5 clock = ~clock;
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(logic [4:0] a, logic [15:0] d);
    addr = a;
    wdata = d;
    wr_en = 1;
    tick(1);
    // Idle cycle so wr_en never changes twice in one step
    wr_en = 0;
    tick(1);
  endtask
  task automatic t_speed;
    logic [15:0] img;
    for (int s = 0; s < 4; s++) begin
      img = {2'h0, s[0], 6'h00, s[1], 6'h00};
      wr(5'h00, img);
      chk(rd, img);
      chk(rsvd, s == 3);
      chk(ctrl.speed, s[1:0]);
    end
    $display("t_speed done");
  endtask
  task automatic t_restart;
    wr(5'h00, 16'h1200);
    chk(restart, 1);
    chk(rd, 16'h1200);
    ack = 1;
    addr = 5'h00;
    wdata = 16'h1200;
    wr_en = 1;
    tick(1);
    chk(restart, 1);
    wr_en = 0;
    tick(1);
    ack = 0;
    chk(restart, 0);
    chk(rd, 16'h1000);
    wr(5'h00, 16'h1000);
    chk(restart, 0);
    $display("t_restart done");
  endtask
  task automatic t_bits;
    wr(5'h00, 16'h4dbf);
    chk(rd, 16'h4d80);
    chk(ctrl, 8'h1f);
    chk(mac_en, 0);
    chk(tx_en, 0);
    wr(5'h01, 16'h0000);
    chk(rd, 16'h4d80);
    wr(5'h00, 16'h0000);
    chk(mac_en, 1);
    chk(tx_en, 1);
    $display("t_bits done");
  endtask
  task automatic t_soft;
    strap = 4'h9;
    wr(5'h00, 16'h8000);
    chk(srst, 1);
    chk(mac_en, 0);
    chk(rd, 16'h8000);
    wr(5'h00, 16'h4000);
    tick(17);
    chk(srst, 1);
    tick(1);
    chk(srst, 0);
    chk(rd, 16'h0840);
    chk(ctrl, 8'h90);
    tick(3);
    chk(tx_en, 0);
    wr(5'h00, 16'h0040);
    chk(tx_en, 1);
    link = 0;
    tick(1);
    chk(tx_en, 0);
    link = 1;
    tick(1);
    $display("t_soft done");
  endtask
  task automatic t_hwreset;
    rst = 1;
    tick(2);
    chk(rd, 16'h0000);
    chk(mac_en, 0);
    rst = 0;
    tick(1);
    chk(rd, 16'h0840);
    chk(tx_en, 0);
    $display("t_hwreset done");
  endtask
  task close_out;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
  end
  initial begin
    tick(8);
    rst = 0;
    tick(2);
    chk(rd, 16'h1040);
    t_speed();
    t_restart();
    t_bits();
    t_soft();
    t_hwreset();
    close_out();
  end
endmodule

//--- tb/pbc_control_properties.sv
`timescale 1ns/1ps
module pbc_control_properties
  import pbc_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        wr_en,
  input wire logic [4:0]  reg_addr,
  input wire logic [15:0] wr_data,
  input wire logic        neg_restart_ack,
  input wire logic        link_valid,
  input wire logic [15:0] rd_data,
  input wire pbc_ctrl_t   ctrl,
  input wire logic        negotiation_restart,
  input wire logic        soft_reset,
  input wire logic        mac_out_enable,
  input wire logic        transmit_enable,
  input wire logic        speed_reserved
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_map; rd_data[6] == ctrl.speed[1] && rd_data[13] == ctrl.speed[0]; endproperty
  a_map: assert property (p_map) else $error("speed map");
  property p_rsv; speed_reserved == (ctrl.speed == 2'h3); endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag");
  property p_neg; rd_data[12] == ctrl.negotiation_enable; endproperty
  a_neg: assert property (p_neg) else $error("neg bit");
  property p_pd; rd_data[11] == ctrl.soft_power_down; endproperty
  a_pd: assert property (p_pd) else $error("pd bit");
  property p_low; rd_data[5:0] == 6'h00; endproperty
  a_low: assert property (p_low) else $error("low bits");
  property p_mac; ctrl.isolate || ctrl.soft_power_down || soft_reset |-> !mac_out_enable; endproperty
  a_mac: assert property (p_mac) else $error("isolate");
  property p_tx; transmit_enable |-> $past(link_valid) && !ctrl.soft_power_down; endproperty
  a_tx: assert property (p_tx) else $error("tx gate");
  property p_ack;
    negotiation_restart && neg_restart_ack && !(wr_en && reg_addr == 5'h00 && wr_data[9])
      |=> !negotiation_restart;
  endproperty
  a_ack: assert property (p_ack) else $error("restart clear");
  property p_sr; $fell(soft_reset) |-> $past(soft_reset, 21) && !$past(soft_reset, 22); endproperty
  a_sr: assert property (p_sr) else $error("soft reset length");
  property p_bits;
    rd_data[14] == ctrl.loopback && rd_data[10] == ctrl.isolate &&
      rd_data[8] == ctrl.full_duplex_select && rd_data[7] == ctrl.collision_signal_test;
  endproperty
  a_bits: assert property (p_bits) else $error("field image");
  property p_self; rd_data[15] == soft_reset && rd_data[9] == negotiation_restart; endproperty
  a_self: assert property (p_self) else $error("self clear image");
  c_srst: cover property (soft_reset);
  c_rsvd: cover property (speed_reserved);
  c_ack: cover property (negotiation_restart && neg_restart_ack);
  c_tx: cover property (transmit_enable);
endmodule
bind pbc_control pbc_control_properties pbc_control_properties_i (
  .clock               (clock),
  .rst                 (rst),
  .wr_en               (wr_en),
  .reg_addr            (reg_addr),
  .wr_data             (wr_data),
  .neg_restart_ack     (neg_restart_ack),
  .link_valid          (link_valid),
  .rd_data             (rd_data),
  .ctrl                (ctrl),
  .negotiation_restart (negotiation_restart),
  .soft_reset          (soft_reset),
  .mac_out_enable      (mac_out_enable),
  .transmit_enable     (transmit_enable),
  .speed_reserved      (speed_reserved)
);
